/* File: test_uart_host_i2c_register_port.sv */
// Self-checking bench: host end and device end joined by the link interface.
// Assumes 40 MHz clock; the bench stands in for the register file behind the device.
`timescale 1ns/1ps
`default_nettype none

module test_uart_host_i2c_register_port;
  import uhp_pkg::*;
  logic        clk, rst, cmd_valid, cmd_read, wr_ready, cmd_ready, rsp_valid, rsp_nack;
  logic        wr_valid, reg_rd, addr_valid, strap_hi, strap_lo;
  logic [6:0]  cmd_dev, own_addr, dev_a;
  logic [7:0]  cmd_sub, cmd_wdata, rsp_data, wr_data, rd_data;
  logic [3:0]  wr_addr, reg_addr;
  logic [1:0]  sel_hi, sel_lo;
  logic [7:0]  reg_model [16];
  logic [11:0] wr_q [$];
  int          n_fail, compares;

  // ---------------------------------------------------------------
  // Design, link and checker
  // ---------------------------------------------------------------
  uhp_bus_if u_uhp_bus_if ();
  uhp_host u_uhp_host (.CLK_I(clk), .RST_I(rst), .bus(u_uhp_bus_if), .CMD_VALID_I(cmd_valid),
    .CMD_READY_O(cmd_ready), .CMD_READ_I(cmd_read), .CMD_DEV_I(cmd_dev), .CMD_SUB_I(cmd_sub),
    .CMD_WDATA_I(cmd_wdata), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
    .RSP_NACK_O(rsp_nack));
  uhp_dev u_uhp_dev (.CLK_I(clk), .RST_I(rst), .bus(u_uhp_bus_if), .ADDR_STRAP_HIGH_I(strap_hi),
    .ADDR_STRAP_LOW_I(strap_lo), .REG_WR_VALID_O(wr_valid), .REG_WR_READY_I(wr_ready),
    .REG_WR_ADDR_O(wr_addr), .REG_WR_DATA_O(wr_data), .REG_RD_O(reg_rd),
    .REG_ADDR_O(reg_addr), .REG_RDATA_I(rd_data), .ADDR_VALID_O(addr_valid),
    .OWN_ADDR_O(own_addr));
  uhp_link_asserts u_uhp_link_asserts (.CLK_I(clk), .RST_I(rst),
    .host_scl_oe(u_uhp_bus_if.host_scl_oe), .host_sda_oe(u_uhp_bus_if.host_sda_oe),
    .dev_sda_oe(u_uhp_bus_if.dev_sda_oe), .scl(u_uhp_bus_if.scl), .sda(u_uhp_bus_if.sda));

  // ---------------------------------------------------------------
  // Straps and register file stand-in
  // ---------------------------------------------------------------
  function automatic logic strap_lvl(input logic [1:0] c, input logic s_c, input logic s_d);
    case (c)
      STRAP_VDD: return 1'b1;
      STRAP_VSS: return 1'b0;
      STRAP_SCL: return s_c;
      default:   return s_d;
    endcase
  endfunction
  assign strap_hi = strap_lvl(sel_hi, u_uhp_bus_if.scl, u_uhp_bus_if.sda);
  assign strap_lo = strap_lvl(sel_lo, u_uhp_bus_if.scl, u_uhp_bus_if.sda);
  assign rd_data = reg_model[reg_addr];

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      reg_model[wr_addr] <= wr_data;
      wr_q.push_back({wr_addr, wr_data});
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole command with a bounded wait; the response pulse is sampled mid-cycle
  task automatic do_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] sub,
                        input logic [7:0] wd);
    int i;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_sub = sub;
    cmd_wdata = wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 9000; i++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) break;
    end
    chk({7'h0, rsp_valid}, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_strap(input logic [1:0] hi, input logic [1:0] lo, input logic [7:0] wd);
    logic [7:0] ea;
    ea = 8'h90 + {3'h0, hi, lo, 1'b0};
    dev_a = ea[7:1];
    rst = 1'b1;
    sel_hi = hi;
    sel_lo = lo;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    do_cmd(DIR_WRITE, dev_a, 8'h28, wd);
    chk({7'h0, rsp_nack}, 8'h00);
    chk(reg_model[5], wd);
    chk({7'h0, addr_valid}, 8'h01);
    chk({1'b0, own_addr}, {1'b0, ea[7:1]});
    do_cmd(DIR_READ, dev_a, 8'h28, 8'h00);
    chk({7'h0, rsp_nack}, 8'h00);
    chk(rsp_data, wd);
  endtask

  task automatic t_ignored_bits();
    do_cmd(DIR_WRITE, dev_a, 8'hC9, 8'h5A);
    chk({7'h0, rsp_nack}, 8'h00);
    chk(reg_model[9], 8'h5A);
    chk({7'h0, spi_sub_is_read(8'hC9)}, 8'h01);
    chk({7'h0, spi_sub_is_read(8'h49)}, 8'h00);
  endtask

  task automatic t_wrong_dev();
    do_cmd(DIR_WRITE, dev_a ^ 7'h01, 8'h20, 8'h77);
    chk({7'h0, rsp_nack}, 8'h01);
    chk(reg_model[4], 8'h00);
  endtask

  task automatic t_bad_channel();
    do_cmd(DIR_WRITE, dev_a, 8'h1A, 8'h66);
    chk({7'h0, rsp_nack}, 8'h01);
    chk(reg_model[3], 8'h00);
  endtask

  // Far side stalls until the buffer refuses, then drains it
  task automatic t_fifo_full();
    int i;
    wr_ready = 1'b0;
    wr_q.delete();
    for (i = 0; i < 16; i++) begin
      do_cmd(DIR_WRITE, dev_a, {1'b0, i[3:0], 3'h0}, 8'(8'hC0 + i));
      chk({7'h0, rsp_nack}, 8'h00);
    end
    do_cmd(DIR_WRITE, dev_a, 8'h00, 8'hFF);
    chk({7'h0, rsp_nack}, 8'h01);
    wr_ready = 1'b1;
    for (i = 0; i < 100 && wr_valid !== 1'b0; i++) @(negedge clk);
    chk(8'(wr_q.size()), 8'h10);
    for (i = 0; i < 16 && i < wr_q.size(); i++) begin
      chk({4'h0, wr_q[i][11:8]}, {4'h0, i[3:0]});
      chk(wr_q[i][7:0], 8'(8'hC0 + i));
    end
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // About 96k cycles; the sequence needs roughly 70k
  initial begin
    #2_400_000;
    n_fail++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_dev = 7'h00;
    cmd_sub = 8'h00;
    cmd_wdata = 8'h00;
    wr_ready = 1'b1;
    sel_hi = STRAP_VSS;
    sel_lo = STRAP_SCL;
    dev_a = 7'h00;
    n_fail = 0;
    compares = 0;
    for (int k = 0; k < 16; k++) reg_model[k] = 8'h00;
    t_strap(STRAP_VSS, STRAP_SCL, 8'hA5);
    t_ignored_bits();
    t_wrong_dev();
    t_bad_channel();
    t_fifo_full();
    t_strap(STRAP_SDA, STRAP_VDD, 8'h3C);
    test_done();
  end
endmodule

`default_nettype wire

/* File: uhp_bus_if.sv */
// Two-wire bus between the host end and the device end.
// Both lines are open drain: a line is low while any enable is high.
`timescale 1ns/1ps
`default_nettype none

interface uhp_bus_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-up resolution of the wired lines
  assign scl = !host_scl_oe;
  assign sda = !(host_sda_oe || dev_sda_oe);

  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev  (output dev_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

/* File: uhp_dev.sv */
// Device end: bus slave giving access to sixteen UART registers.
// Assumes SCL/SDA and the straps are asynchronous pins; the UART side
// answers a read strobe with data on the following clock.
`timescale 1ns/1ps
`default_nettype none

module uhp_dev
  import uhp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  uhp_bus_if.dev           bus,
  input  wire logic        ADDR_STRAP_HIGH_I,
  input  wire logic        ADDR_STRAP_LOW_I,
  output logic             REG_WR_VALID_O,
  input  wire logic        REG_WR_READY_I,
  output logic [3:0]       REG_WR_ADDR_O,
  output logic [7:0]       REG_WR_DATA_O,
  output logic             REG_RD_O,
  output logic [3:0]       REG_ADDR_O,
  input  wire logic [7:0]  REG_RDATA_I,
  output logic             ADDR_VALID_O,
  output logic [6:0]       OWN_ADDR_O
);
  import uhp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RXB  = 3'h1,
    D_ACKO = 3'h2,
    D_TXB  = 3'h3,
    D_ACKI = 3'h4,
    D_WAIT = 3'h5
  } uhp_dst_e;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_SUB  = 2'h1,
    K_DATA = 2'h2
  } uhp_kind_e;

  typedef struct packed {
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic        scl_d;
    logic        sda_d;
    logic [2:0]  hi_f;
    logic [2:0]  lo_f;
    logic        addr_ok;
    logic [6:0]  my_addr;
    uhp_dst_e    st;
    uhp_kind_e   kind;
    logic        rw;
    logic [3:0]  bcnt;
    logic [7:0]  sh;
    logic [3:0]  rg;
    logic        chan_ok;
    logic        sda_oe;
    logic        rd_o;
    logic        rd_pend;
    logic [7:0]  rdbuf;
    logic        push;
    logic [11:0] push_data;
  } uhp_dev_s;

  uhp_dev_s q;
  uhp_dev_s n;

  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic fifo_ready;

  // Only the second stage is read; the first stage only feeds it
  assign scl   = q.sy2[0];
  assign sda   = q.sy2[1];
  assign rise  = scl && !q.scl_d;
  assign fall  = !scl && q.scl_d;
  assign start = scl && q.scl_d && q.sda_d && !sda;
  assign stop  = scl && q.scl_d && !q.sda_d && sda;

  // ---------------------------------------------------------------
  // Write path buffer
  // ---------------------------------------------------------------
  // Full buffer turns into a nack rather than a lost byte
  uhp_fifo #(.W(12), .D(16)) u_wfifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (q.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (q.push_data),
    .out_valid_o (REG_WR_VALID_O),
    .out_ready_i (REG_WR_READY_I),
    .out_data_o  ({REG_WR_ADDR_O, REG_WR_DATA_O})
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n       = q;
    n.rd_o  = 1'b0;
    n.push  = 1'b0;
    n.sy1   = {ADDR_STRAP_LOW_I, ADDR_STRAP_HIGH_I, bus.sda, bus.scl};
    n.sy2   = q.sy1;
    n.scl_d = scl;
    n.sda_d = sda;
    n.rd_pend = q.rd_o;
    if (q.rd_pend) begin
      n.rdbuf = REG_RDATA_I;
    end

    // Straps watched until the first SCL fall after START; before that SDA moves only for the START itself
    if (!q.addr_ok) begin
      n.hi_f = strap_track(q.hi_f, q.sy2[2], scl, sda);
      n.lo_f = strap_track(q.lo_f, q.sy2[3], scl, sda);
      if (fall && q.st != D_IDLE) begin
        n.addr_ok = 1'b1;
        n.my_addr = DEV_ADDR_BASE + {3'h0, strap_code(n.hi_f), strap_code(n.lo_f)};
      end
    end

    if (stop) begin
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.st     = D_RXB;
      n.kind   = K_ADDR;
      n.bcnt   = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      case (q.st)
        D_RXB: begin
          if (rise && q.bcnt < BYTE_BITS) begin
            n.sh   = {q.sh[6:0], sda};
            n.bcnt = q.bcnt + 4'h1;
          end
          if (fall && q.bcnt == BYTE_BITS) begin
            n.bcnt = 4'h0;
            case (q.kind)
              K_ADDR: begin
                if (q.addr_ok && q.sh[7:1] == q.my_addr) begin
                  n.rw     = q.sh[0];
                  n.sda_oe = 1'b1;
                  n.st     = D_ACKO;
                  n.rd_o   = q.sh[0] == DIR_READ;
                end else begin
                  n.st = D_WAIT;
                end
              end
              K_SUB: begin
                n.rg      = sub_reg(q.sh);
                n.chan_ok = sub_chan_ok(q.sh);
                n.sda_oe  = 1'b1;
                n.st      = D_ACKO;
              end
              default: begin
                if (q.chan_ok && fifo_ready) begin
                  n.push      = 1'b1;
                  n.push_data = {q.rg, q.sh};
                  n.rg        = q.rg + 4'h1;
                  n.sda_oe    = 1'b1;
                  n.st        = D_ACKO;
                end else begin
                  n.st = D_WAIT;
                end
              end
            endcase
          end
        end
        D_ACKO: begin
          if (fall) begin
            if (q.kind == K_ADDR && q.rw == DIR_READ) begin
              n.st     = D_TXB;
              n.sh     = q.rdbuf;
              n.sda_oe = !q.rdbuf[7];
              n.rg     = q.rg + 4'h1;
              n.bcnt   = 4'h0;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = D_RXB;
              n.kind   = (q.kind == K_ADDR) ? K_SUB : K_DATA;
            end
          end
        end
        D_TXB: begin
          // Data changes only after SCL is seen low
          if (fall) begin
            if (q.bcnt == BYTE_BITS - 4'h1) begin
              n.sda_oe = 1'b0;
              n.st     = D_ACKI;
            end else begin
              n.sh     = {q.sh[6:0], 1'b0};
              n.sda_oe = !q.sh[6];
              n.bcnt   = q.bcnt + 4'h1;
            end
          end
        end
        D_ACKI: begin
          if (rise) begin
            if (sda) begin
              n.st = D_WAIT;
            end else begin
              n.rd_o = 1'b1;
            end
          end else if (fall) begin
            n.st     = D_TXB;
            n.sh     = q.rdbuf;
            n.sda_oe = !q.rdbuf[7];
            n.rg     = q.rg + 4'h1;
            n.bcnt   = 4'h0;
          end
        end
        D_IDLE, D_WAIT: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.st     = D_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q         <= '0;
      q.sy1     <= 4'hF;
      q.sy2     <= 4'hF;
      q.scl_d   <= 1'b1;
      q.sda_d   <= 1'b1;
      q.st      <= D_IDLE;
      q.kind    <= K_ADDR;
    end else begin
      q <= n;
    end
  end

  assign bus.dev_sda_oe = q.sda_oe;
  assign REG_RD_O       = q.rd_o;
  assign REG_ADDR_O     = q.rg;
  assign ADDR_VALID_O   = q.addr_ok;
  assign OWN_ADDR_O     = q.my_addr;
endmodule

`default_nettype wire

/* File: uhp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; data out is the head word while out_valid is high.
`timescale 1ns/1ps
`default_nettype none

module uhp_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         full;
  logic         empty;

  assign empty       = wp_ff == rp_ff;
  assign full        = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rp_ff[AW-1:0]];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end

  // Storage needs no reset; only the pointers define content
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule

`default_nettype wire

/* File: uhp_host.sv */
// Host end: bus master doing one-register writes and reads.
// Assumes the device never stretches SCL; SCL is made here by a divider.
`timescale 1ns/1ps
`default_nettype none

module uhp_host
  import uhp_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  uhp_bus_if.host         bus,
  input  wire logic       CMD_VALID_I,
  output logic            CMD_READY_O,
  input  wire logic       CMD_READ_I,
  input  wire logic [6:0] CMD_DEV_I,
  input  wire logic [7:0] CMD_SUB_I,
  input  wire logic [7:0] CMD_WDATA_I,
  output logic            RSP_VALID_O,
  output logic [7:0]      RSP_DATA_O,
  output logic            RSP_NACK_O
);
  import uhp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BYTE  = 2'h2,
    H_STOP  = 2'h3
  } uhp_hst_e;

  typedef struct packed {
    logic       sy1;
    logic       sy2;
    uhp_hst_e   st;
    logic [4:0] qc;
    logic [1:0] ph;
    logic [2:0] idx;
    logic [3:0] bitn;
    logic       rx;
    logic [7:0] sh;
    logic       rd;
    logic [6:0] dev;
    logic [7:0] sub;
    logic [7:0] wdata;
    logic       fail;
    logic       scl_oe;
    logic       sda_oe;
    logic       rsp_v;
    logic [7:0] rsp_d;
    logic       rsp_n;
  } uhp_host_s;

  uhp_host_s q;
  uhp_host_s n;
  logic      tick;
  logic      done;

  assign tick = q.qc == 5'(QTR_CYC - 1);
  assign done = tick && q.ph == 2'h3;

  // ---------------------------------------------------------------
  // Sequencer: write = S A+W sub data P, read = S A+W sub Sr A+R byte P
  // ---------------------------------------------------------------
  always_comb begin
    n       = q;
    n.sy1   = bus.sda;
    n.sy2   = q.sy1;
    n.rsp_v = 1'b0;
    if (q.st != H_IDLE) begin
      n.qc = tick ? 5'h0 : q.qc + 5'h1;
      if (tick) begin
        n.ph = q.ph + 2'h1;
      end
    end
    case (q.st)
      H_IDLE: begin
        if (CMD_VALID_I) begin
          n.rd    = CMD_READ_I;
          n.dev   = CMD_DEV_I;
          n.sub   = CMD_SUB_I;
          n.wdata = CMD_WDATA_I;
          n.fail  = 1'b0;
          n.idx   = 3'h0;
          n.st    = H_START;
          n.qc    = 5'h0;
          n.ph    = 2'h0;
        end
      end
      H_BYTE: begin
        if (done) begin
          n.bitn = q.bitn + 4'h1;
          if (q.bitn < BYTE_BITS) begin
            n.sh = {q.sh[6:0], q.sy2};
          end else if (!q.rx && q.sy2) begin
            n.fail = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (q.st != H_IDLE && done && !(q.st == H_BYTE && q.bitn < BYTE_BITS)) begin
      n.bitn = 4'h0;
      n.rx   = 1'b0;
      n.st   = H_BYTE;
      if (q.st == H_BYTE && !q.rx && q.sy2) begin
        n.idx = 3'h6;
        n.st  = H_STOP;
      end else begin
        case (q.idx)
          3'h0: begin
            n.idx = 3'h1;
            n.sh  = {q.dev, DIR_WRITE};
          end
          3'h1: begin
            n.idx = 3'h2;
            n.sh  = q.sub;
          end
          3'h2: begin
            n.idx = 3'h3;
            n.sh  = q.wdata;
            if (q.rd) begin
              n.st = H_START;
            end
          end
          3'h3: begin
            n.idx = q.rd ? 3'h4 : 3'h6;
            n.sh  = {q.dev, DIR_READ};
            if (!q.rd) begin
              n.st = H_STOP;
            end
          end
          3'h4: begin
            n.idx = 3'h5;
            n.rx  = 1'b1;
          end
          3'h5: begin
            n.idx   = 3'h6;
            n.rsp_d = q.sh;
            n.st    = H_STOP;
          end
          default: begin
            n.st    = H_IDLE;
            n.rsp_v = 1'b1;
            n.rsp_n = q.fail;
          end
        endcase
      end
    end

    // Line levels follow the phase: in a bit SCL is low in phases 0-1 and high in 2-3; in START and STOP it is low only in phase 0
    case (n.st)
      H_START: begin
        n.scl_oe = n.ph == 2'h0;
        n.sda_oe = n.ph[1];
      end
      H_BYTE: begin
        n.scl_oe = !n.ph[1];
        if (n.rx || n.bitn == BYTE_BITS) begin
          n.sda_oe = 1'b0;
        end else begin
          n.sda_oe = !n.sh[7];
        end
      end
      H_STOP: begin
        n.scl_oe = n.ph == 2'h0;
        n.sda_oe = !n.ph[1];
      end
      default: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q     <= '0;
      q.sy1 <= 1'b1;
      q.sy2 <= 1'b1;
      q.st  <= H_IDLE;
    end else begin
      q <= n;
    end
  end

  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_oe = q.sda_oe;
  assign CMD_READY_O     = q.st == H_IDLE;
  assign RSP_VALID_O     = q.rsp_v;
  assign RSP_DATA_O      = q.rsp_d;
  assign RSP_NACK_O      = q.rsp_n;
endmodule

`default_nettype wire

/* File: uhp_link_asserts.sv */
// Concurrent checks on the two-wire link between the host and device ends.
// Assumes it sits beside the link interface and sees the system clock and reset.
`timescale 1ns/1ps
`default_nettype none

module uhp_link_asserts (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ---------------------------------------------------------------
  // Framing helper
  // ---------------------------------------------------------------
  logic       scl_ff;
  logic       sda_ff;
  logic       first_ff;
  logic       nxt_first;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic [7:0] hi_ff;
  logic [7:0] nxt_hi;
  logic       start_w;

  assign start_w = scl && scl_ff && sda_ff && !sda;

  always_comb begin
    nxt_bit = bit_ff;
    nxt_first = first_ff;
    nxt_hi = 8'h00;
    if (scl) begin
      nxt_hi = (hi_ff == 8'hFF) ? hi_ff : hi_ff + 8'h01;
    end
    if (start_w) begin
      nxt_bit = 4'h0;
      nxt_first = 1'b1;
    end else if (scl && !scl_ff) begin
      nxt_bit = (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      if (bit_ff == 4'h8) begin
        nxt_first = 1'b0;
      end
    end
  end

  // Saturated at reset so the first high phase after reset is not judged
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      first_ff <= 1'b0;
      bit_ff <= 4'h0;
      hi_ff <= 8'hFF;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      first_ff <= nxt_first;
      bit_ff <= nxt_bit;
      hi_ff <= nxt_hi;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_start_by_host: assert property (start_w |-> host_sda_oe)
    else $error("start condition not made by host");
  a_dev_rise_low: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device pulled data while clock high");
  a_dev_fall_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released data while clock high");
  a_dev_data_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data changed in clock high phase");
  a_scl_high_min: assert property ($fell(scl) |-> hi_ff >= 8'd20)
    else $error("clock high phase too short");
  a_scl_low_bound: assert property ($fell(scl) |-> ##[1:60] scl)
    else $error("clock low phase too long");
  a_no_contention: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data in clock high phase");
  a_ack_stands: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("device bit dropped early in high phase");
  a_addr_ack_slot: assert property ($rose(dev_sda_oe) && first_ff |-> bit_ff == 4'h8)
    else $error("device drove data inside the address byte");

  c_start: cover property (start_w);
  c_addr_ack: cover property ($rose(dev_sda_oe) && first_ff);
  c_stop: cover property (scl && scl_ff && !sda_ff && sda);
  c_dev_bit: cover property ($rose(scl) && dev_sda_oe && !first_ff);
endmodule

`default_nettype wire

/* File: uhp_pkg.sv */
// Shared constants and helpers for the serial host register port.
// Assumes a 40 MHz system clock on both ends of the link.
package uhp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int QTR_NS  = 625;
  localparam int QTR_CYC = (QTR_NS * CLK_MHZ) / 1000;

  // ---------------------------------------------------------------
  // Byte and address layout
  // ---------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h48;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic [1:0] CHAN_ZERO     = 2'h0;
  localparam int         SUB_REG_MSB   = 6;
  localparam int         SUB_REG_LSB   = 3;
  localparam int         SUB_CH_MSB    = 2;
  localparam int         SUB_CH_LSB    = 1;
  localparam int         SUB_SPI_DIR   = 7;

  // Strap connection codes
  localparam logic [1:0] STRAP_VDD = 2'h0;
  localparam logic [1:0] STRAP_VSS = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] sub_reg(input logic [7:0] b);
    return b[SUB_REG_MSB:SUB_REG_LSB];
  endfunction

  function automatic logic sub_chan_ok(input logic [7:0] b);
    return b[SUB_CH_MSB:SUB_CH_LSB] == CHAN_ZERO;
  endfunction

  // SPI framing reuses the layout, with the direction in the top bit
  function automatic logic spi_sub_is_read(input logic [7:0] b);
    return b[SUB_SPI_DIR] == DIR_READ;
  endfunction

  // Flags: {seen_low, mismatch_scl, mismatch_sda}
  function automatic logic [1:0] strap_code(input logic [2:0] f);
    if (f[2] && !f[1]) begin
      return STRAP_SCL;
    end else if (f[2] && !f[0]) begin
      return STRAP_SDA;
    end else if (f[2]) begin
      return STRAP_VSS;
    end
    return STRAP_VDD;
  endfunction

  function automatic logic [2:0] strap_track(input logic [2:0] f, input logic p,
                                             input logic scl, input logic sda);
    return f | {!p, p != scl, p != sda};
  endfunction

endpackage
